// *** inc/dacs_pkg.sv ***
/*
 * Package for the accumulator datapath: widths, saturation limits, rounding
 * constants, operation encodings and the packed carriers between files.
 * Assumes a single core clock and no register bus.
 */
package dacs_pkg;

    localparam int ACC_W  = 40;
    localparam int WORD_W = 16;

    localparam int GUARD_LO = 32;
    localparam int SIGN39   = 39;
    localparam int SIGN31   = 31;
    localparam int HI_LO    = 16;
    localparam int RND_BIT  = 15;

    localparam logic [39:0] SUPER_POS  = 40'h7f_ffff_ffff;
    localparam logic [39:0] SUPER_NEG  = 40'h80_0000_0000;
    localparam logic [39:0] NORMAL_POS = 40'h00_7fff_ffff;
    localparam logic [39:0] NORMAL_NEG = 40'h00_8000_0000;

    localparam logic [15:0] LOW_HALF   = 16'h8000;
    localparam logic [15:0] WORD_POS   = 16'h7fff;
    localparam logic [15:0] WORD_NEG   = 16'h8000;
    localparam logic [15:0] PTR_STEP   = 16'h0002;

    localparam logic [39:0] ACC_RESET  = 40'h00_0000_0000;
    localparam logic [15:0] PTR_RESET  = 16'h0000;

    // Accumulator operations presented by the decoder
    typedef enum logic [3:0] {
        DACS_OP_NONE         = 4'h0,
        DACS_OP_ADD          = 4'h1,
        DACS_OP_SUB          = 4'h2,
        DACS_OP_LOAD         = 4'h3,
        DACS_OP_MULT_ACCUM   = 4'h4,
        DACS_OP_MULT_SUB     = 4'h5,
        DACS_OP_MULTIPLY     = 4'h6,
        DACS_OP_NEG_MULTIPLY = 4'h7,
        DACS_OP_DIFF_SQ      = 4'h8,
        DACS_OP_DIFF_SQ_ACC  = 4'h9,
        DACS_OP_STORE        = 4'ha,
        DACS_OP_STORE_RND    = 4'hb
    } dacs_op_type;

    typedef enum logic [1:0] {
        DACS_WB_NONE     = 2'b00,
        DACS_WB_REG      = 2'b01,
        DACS_WB_POST_INC = 2'b11
    } dacs_wb_type;

    // Configuration bits, core control and trap control fields
    typedef struct packed {
        logic first_acc_clip_en;
        logic second_acc_clip_en;
        logic store_clip_en;
        logic clip_width_sel;
        logic round_style_sel;
        logic first_guard_trap_en;
        logic second_guard_trap_en;
        logic fatal_ovf_trap_en;
    } dacs_cfg_type;

    typedef struct packed {
        dacs_op_type  op;
        logic         target_sel;
        logic         shift_en;
        logic [39:0]  operand;
        logic [39:0]  shifted;
        dacs_wb_type  wb_mode;
    } dacs_req_type;

    typedef struct packed {
        logic        first_acc_guard_ovf;
        logic        second_acc_guard_ovf;
        logic        first_acc_clip_flag;
        logic        second_acc_clip_flag;
        logic        any_acc_guard_ovf;
        logic        any_acc_clip_flag;
    } dacs_flags_type;

endpackage

// *** design/dacs_round_word.sv ***
/*
 * Round and store-saturate: turns a 40-bit accumulator into a 1.15 word.
 * Purely combinational; assumes the caller registers the result.
 */
`timescale 1ns/1ps
module dacs_round_word
    import dacs_pkg::*;
(
    input  wire logic [39:0] acc_in,
    input  wire logic        round_en_in,
    input  wire logic        round_style_in,
    input  wire logic        clip_en_in,
    output logic      [15:0] word_out
);
    logic [15:0] low_word;
    logic        inc;
    logic [24:0] sum;

    always_comb begin
        low_word  = acc_in[15:0];
        inc       = 1'b0;
        if (round_en_in) begin
            if (round_style_in) begin
                inc = acc_in[RND_BIT];
            end else if (low_word == LOW_HALF) begin
                inc = acc_in[HI_LO];
            end else begin
                inc = acc_in[RND_BIT];
            end
        end
        // Upper 24 bits plus the round increment, sign-tracked
        sum = {acc_in[39], acc_in[39:16]} + {24'h00_0000, inc};
        word_out = sum[15:0];
        if (clip_en_in) begin
            if (!acc_in[39] && sum[24:15] != 10'h000) begin
                word_out = WORD_POS;
            end else if (acc_in[39] && sum[24:15] != 10'h3ff) begin
                word_out = WORD_NEG;
            end
        end
    end
endmodule // dacs_round_word

// *** design/dacs_acc_sat.sv ***
/*
 * Saturation and flag next-state for one accumulator result.
 * Assumes a raw 41-bit adder result with an extra sign bit.
 */
`timescale 1ns/1ps
module dacs_acc_sat
    import dacs_pkg::*;
(
    input  wire logic [40:0] raw_in,
    input  wire logic        sat_en_in,
    input  wire logic        width_sel_in,
    output logic      [39:0] acc_out,
    output logic             guard_ovf_out,
    output logic             clip_set_out
);
    logic ovf39;
    logic ovf31;
    logic neg;

    always_comb begin
        neg   = raw_in[40];
        ovf39 = raw_in[40] ^ raw_in[39];
        ovf31 = (raw_in[40:31] != 10'h000) && (raw_in[40:31] != 10'h3ff);
        guard_ovf_out = (raw_in[39:32] != 8'h00) && (raw_in[39:32] != 8'hff);
        acc_out       = raw_in[39:0];
        clip_set_out  = ovf39;
        if (sat_en_in) begin
            if (width_sel_in) begin
                clip_set_out = ovf39;
                if (ovf39) begin
                    acc_out = neg ? SUPER_NEG : SUPER_POS;
                end
            end else begin
                clip_set_out  = ovf31;
                guard_ovf_out = 1'b0;
                if (ovf31) begin
                    acc_out = neg ? NORMAL_NEG : NORMAL_POS;
                end
            end
        end
    end
endmodule // dacs_acc_sat

// *** design/dacs_accum.sv ***
/*
 * Accumulator datapath: 40-bit adder/subtracter over two accumulators,
 * saturation, guard and sticky clip flags, traps, rounding store and write-back.
 * Assumes the decoder presents one operation per cycle with the multiplier
 * product or data in req_in.operand and its shifted form in req_in.shifted.
 */
`timescale 1ns/1ps
module dacs_accum
    import dacs_pkg::*;
(
    input  wire logic           clk_in,
    input  wire logic           rstn_in,
    input  wire dacs_cfg_type   cfg_in,
    input  wire dacs_req_type   req_in,
    input  wire logic           clear_first_clip_in,
    input  wire logic           clear_second_clip_in,
    output logic      [39:0]    first_acc_out,
    output logic      [39:0]    second_acc_out,
    output dacs_flags_type      flags_out,
    output logic                arith_trap_out,
    output logic                xbus_wr_out,
    output logic      [15:0]    xbus_addr_out,
    output logic      [15:0]    xbus_data_out,
    output logic      [15:0]    writeback_ptr_out
);
    logic [39:0] acc_q [2];
    logic [39:0] acc_d [2];
    logic [1:0]  guard_q;
    logic [1:0]  guard_d;
    logic [1:0]  clip_q;
    logic [1:0]  clip_d;
    logic        trap_q;
    logic        trap_d;
    logic        wr_q;
    logic        wr_d;
    logic [15:0] addr_q;
    logic [15:0] addr_d;
    logic [15:0] data_q;
    logic [15:0] data_d;
    logic [15:0] ptr_q;
    logic [15:0] ptr_d;

    logic [39:0] src;
    logic [39:0] opnd;
    logic [39:0] other;
    logic [40:0] raw;
    logic        adder_used;
    logic        sub;
    logic        sat_en;
    logic [39:0] sat_acc;
    logic        guard_new;
    logic        clip_new;
    logic        store_op;
    logic        wb_op;
    logic [15:0] store_word;
    logic [15:0] wb_word;

    // Add, accumulate, load and multiply forms pass through the adder
    always_comb begin
        src        = acc_q[req_in.target_sel];
        other      = acc_q[~req_in.target_sel];
        opnd       = req_in.operand;
        sub        = 1'b0;
        adder_used = 1'b1;
        case (req_in.op)
            DACS_OP_ADD: begin
                if (req_in.shift_en) begin
                    opnd = req_in.shifted;
                end
            end
            DACS_OP_LOAD: begin
                src = ACC_RESET;
                if (req_in.shift_en) begin
                    opnd = req_in.shifted;
                end
            end
            DACS_OP_SUB,
            DACS_OP_MULT_SUB: begin
                sub = 1'b1;
            end
            DACS_OP_MULTIPLY,
            DACS_OP_NEG_MULTIPLY,
            DACS_OP_DIFF_SQ: begin
                src = ACC_RESET;
                sub = (req_in.op == DACS_OP_NEG_MULTIPLY);
            end
            DACS_OP_MULT_ACCUM,
            DACS_OP_DIFF_SQ_ACC: begin
                sub = 1'b0;
            end
            default: begin
                adder_used = 1'b0;
            end
        endcase
        // Complemented data with an active-low borrow (carry in = 1)
        if (sub) begin
            raw = {src[39], src} + {~opnd[39], ~opnd} + 41'h001;
        end else begin
            raw = {src[39], src} + {opnd[39], opnd};
        end
        sat_en = req_in.target_sel ? cfg_in.second_acc_clip_en
                                   : cfg_in.first_acc_clip_en;
        store_op = (req_in.op == DACS_OP_STORE) || (req_in.op == DACS_OP_STORE_RND);
        wb_op    = (req_in.wb_mode != DACS_WB_NONE)
                 && ((req_in.op == DACS_OP_MULT_ACCUM)
                 ||  (req_in.op == DACS_OP_MULT_SUB));
    end

    dacs_acc_sat u_sat (
        .raw_in        (raw),
        .sat_en_in     (sat_en),
        .width_sel_in  (cfg_in.clip_width_sel),
        .acc_out       (sat_acc),
        .guard_ovf_out (guard_new),
        .clip_set_out  (clip_new)
    );

    dacs_round_word u_store_round (
        .acc_in         (src),
        .round_en_in    (req_in.op == DACS_OP_STORE_RND),
        .round_style_in (cfg_in.round_style_sel),
        .clip_en_in     (cfg_in.store_clip_en),
        .word_out       (store_word)
    );

    dacs_round_word u_wb_round (
        .acc_in         (other),
        .round_en_in    (1'b1),
        .round_style_in (cfg_in.round_style_sel),
        .clip_en_in     (cfg_in.store_clip_en),
        .word_out       (wb_word)
    );

    always_comb begin
        acc_d   = acc_q;
        guard_d = guard_q;
        clip_d  = clip_q;
        ptr_d   = ptr_q;
        wr_d    = 1'b0;
        addr_d  = addr_q;
        data_d  = data_q;
        if (adder_used) begin
            acc_d[req_in.target_sel]   = sat_acc;
            guard_d[req_in.target_sel] = guard_new;
        end
        // Software clear first, so a same-cycle set wins
        if (clear_first_clip_in) begin
            clip_d[0] = 1'b0;
        end
        if (clear_second_clip_in) begin
            clip_d[1] = 1'b0;
        end
        if (adder_used && clip_new) begin
            clip_d[req_in.target_sel] = 1'b1;
        end
        if (store_op) begin
            wr_d   = 1'b1;
            addr_d = ptr_q;
            data_d = store_word;
        end else if (wb_op) begin
            if (req_in.wb_mode == DACS_WB_REG) begin
                ptr_d = wb_word;
            end else begin
                wr_d   = 1'b1;
                addr_d = ptr_q;
                data_d = wb_word;
                ptr_d  = ptr_q + PTR_STEP;
            end
        end
        trap_d = (guard_d[0] && cfg_in.first_guard_trap_en)
               || (guard_d[1] && cfg_in.second_guard_trap_en)
               || (cfg_in.fatal_ovf_trap_en && (clip_d[0] && !cfg_in.first_acc_clip_en
                   || clip_d[1] && !cfg_in.second_acc_clip_en));
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            acc_q[0] <= ACC_RESET;
            acc_q[1] <= ACC_RESET;
            guard_q  <= 2'b00;
            clip_q   <= 2'b00;
            trap_q   <= 1'b0;
            wr_q     <= 1'b0;
            addr_q   <= PTR_RESET;
            data_q   <= 16'h0000;
            ptr_q    <= PTR_RESET;
        end else begin
            acc_q    <= acc_d;
            guard_q  <= guard_d;
            clip_q   <= clip_d;
            trap_q   <= trap_d;
            wr_q     <= wr_d;
            addr_q   <= addr_d;
            data_q   <= data_d;
            ptr_q    <= ptr_d;
        end
    end

    assign first_acc_out                  = acc_q[0];
    assign second_acc_out                 = acc_q[1];
    assign flags_out.first_acc_guard_ovf  = guard_q[0];
    assign flags_out.second_acc_guard_ovf = guard_q[1];
    assign flags_out.first_acc_clip_flag  = clip_q[0];
    assign flags_out.second_acc_clip_flag = clip_q[1];
    assign flags_out.any_acc_guard_ovf    = guard_q[0] | guard_q[1];
    assign flags_out.any_acc_clip_flag    = clip_q[0] | clip_q[1];
    assign arith_trap_out                 = trap_q;
    assign xbus_wr_out                    = wr_q;
    assign xbus_addr_out                  = addr_q;
    assign xbus_data_out                  = data_q;
    assign writeback_ptr_out              = ptr_q;
endmodule // dacs_accum

// *** dv/dacs_accum_properties.sv ***
/* Concurrent checks on the accumulator datapath ports.
 * Bound to dacs_accum from the bench; one clock, sync active-low reset. */
`timescale 1ns/1ps
module dacs_accum_properties
    import dacs_pkg::*;
(
    input  wire logic           clk_in,
    input  wire logic           rstn_in,
    input  wire dacs_cfg_type   cfg_in,
    input  wire dacs_req_type   req_in,
    input  wire logic           clear_first_clip_in,
    input  wire logic           clear_second_clip_in,
    input  wire logic [39:0]    first_acc_out,
    input  wire logic [39:0]    second_acc_out,
    input  wire dacs_flags_type flags_out,
    input  wire logic           arith_trap_out,
    input  wire logic           xbus_wr_out,
    input  wire logic [15:0]    xbus_addr_out,
    input  wire logic [15:0]    xbus_data_out,
    input  wire logic [15:0]    writeback_ptr_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    a_any_guard_or: assert property (
        flags_out.any_acc_guard_ovf == (flags_out.first_acc_guard_ovf | flags_out.second_acc_guard_ovf))
        else $error("combined guard flag wrong");
    a_any_clip_or: assert property (
        flags_out.any_acc_clip_flag == (flags_out.first_acc_clip_flag | flags_out.second_acc_clip_flag))
        else $error("combined clip flag wrong");
    a_clip_sticky: assert property (
        flags_out.first_acc_clip_flag && !clear_first_clip_in |=> flags_out.first_acc_clip_flag)
        else $error("clip flag dropped without clear");
    a_store_write: assert property (
        req_in.op inside {DACS_OP_STORE, DACS_OP_STORE_RND}
        |=> xbus_wr_out && xbus_addr_out == $past(writeback_ptr_out))
        else $error("store did not write at pointer");
    a_mult_no_wb: assert property (
        req_in.op inside {DACS_OP_MULTIPLY, DACS_OP_NEG_MULTIPLY, DACS_OP_DIFF_SQ, DACS_OP_DIFF_SQ_ACC}
        |=> !xbus_wr_out && $stable(writeback_ptr_out))
        else $error("multiply form wrote back");
    a_post_inc: assert property (
        req_in.op == DACS_OP_MULT_ACCUM && req_in.wb_mode == DACS_WB_POST_INC
        |=> xbus_wr_out && writeback_ptr_out == $past(writeback_ptr_out) + PTR_STEP)
        else $error("post increment write-back wrong");
    a_normal_noguard: assert property (
        req_in.op inside {DACS_OP_ADD, DACS_OP_SUB} && !req_in.target_sel
        && cfg_in.first_acc_clip_en && !cfg_in.clip_width_sel |=> !flags_out.first_acc_guard_ovf)
        else $error("guard flag set in normal saturation");
    a_other_acc_held: assert property (
        req_in.op inside {DACS_OP_ADD, DACS_OP_SUB, DACS_OP_LOAD} && !req_in.target_sel
        |=> $stable(second_acc_out))
        else $error("non-target accumulator changed");
    a_guard_trap: assert property (
        $past(cfg_in.first_guard_trap_en) && flags_out.first_acc_guard_ovf |-> arith_trap_out)
        else $error("guard overflow trap missing");

    c_clip_set: cover property ($rose(flags_out.first_acc_clip_flag));
    c_post_inc: cover property (req_in.op == DACS_OP_MULT_ACCUM && req_in.wb_mode == DACS_WB_POST_INC);
    c_trap: cover property ($rose(arith_trap_out));
endmodule // dacs_accum_properties

// *** dv/dacs_xbus_model.sv ***
/* X data bus sink standing in for data memory.
 * Captures each one-cycle write strobe from the accumulator datapath. */
`timescale 1ns/1ps
module dacs_xbus_model
    import dacs_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        wr_in,
    input  wire logic [15:0] addr_in,
    input  wire logic [15:0] data_in,
    output logic      [15:0] last_addr_out,
    output logic      [15:0] last_data_out
);
    // Only the latest word write is kept
    always_ff @(posedge clk_in) begin
        if (wr_in) begin
            last_addr_out <= addr_in;
            last_data_out <= data_in;
        end
    end
endmodule // dacs_xbus_model

// *** dv/dacs_accum_bench.sv ***
/* Self-checking bench for the accumulator datapath.
 * Drives ops 1 ns after each rising edge; the X bus sink stands as far side. */
`timescale 1ns/1ps
module dacs_accum_bench
    import dacs_pkg::*;
;
    logic           clk_in;
    logic           rstn_in;
    dacs_cfg_type   cfg;
    dacs_req_type   req;
    logic           clr_a;
    logic           clr_b;
    logic [39:0]    acc_a;
    logic [39:0]    acc_b;
    dacs_flags_type flg;
    logic           trap;
    logic           wr;
    logic [15:0]    addr;
    logic [15:0]    data;
    logic [15:0]    ptr;
    logic [15:0]    m_addr;
    logic [15:0]    m_data;
    int             err_total;
    int             checks;
    dacs_op_type    nw [4] = '{DACS_OP_MULTIPLY, DACS_OP_NEG_MULTIPLY, DACS_OP_DIFF_SQ, DACS_OP_DIFF_SQ_ACC};

    initial clk_in = 1'b0;
    always #20 clk_in = ~clk_in;

    dacs_accum uut (.clk_in(clk_in), .rstn_in(rstn_in), .cfg_in(cfg), .req_in(req),
        .clear_first_clip_in(clr_a), .clear_second_clip_in(clr_b), .first_acc_out(acc_a),
        .second_acc_out(acc_b), .flags_out(flg), .arith_trap_out(trap), .xbus_wr_out(wr),
        .xbus_addr_out(addr), .xbus_data_out(data), .writeback_ptr_out(ptr));
    dacs_xbus_model xmem (.clk_in(clk_in), .wr_in(wr), .addr_in(addr), .data_in(data),
        .last_addr_out(m_addr), .last_data_out(m_data));

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkf(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // One op for one cycle after an idle edge; the shifted form is the operand doubled
    task automatic op(input dacs_op_type o, input logic t, input logic [39:0] v,
                      input dacs_wb_type w = DACS_WB_NONE);
        @(posedge clk_in);
        #1 req.op = o;
        req.target_sel = t;
        req.operand = v;
        req.shifted = {v[38:0], 1'b0};
        req.wb_mode = w;
        @(posedge clk_in);
        #1 req.op = DACS_OP_NONE;
        req.wb_mode = DACS_WB_NONE;
        req.shift_en = 1'b0;
    endtask

    task automatic clr();
        clr_a = 1'b1;
        clr_b = 1'b1;
        @(posedge clk_in);
        #1 clr_a = 1'b0;
        clr_b = 1'b0;
    endtask

    task automatic st(input logic [39:0] a, input dacs_op_type o, input logic rs, input logic sc,
                      input logic [15:0] e);
        cfg.round_style_sel = rs;
        cfg.store_clip_en = sc;
        op(DACS_OP_LOAD, 1'b0, a);
        op(o, 1'b0, 40'h00_0000_0000);
        chk({24'h00_0000, data}, {24'h00_0000, e});
        chkf(wr, 1'b1);
        chk(acc_a, a);
    endtask

    task automatic t_add();
        op(DACS_OP_LOAD, 1'b0, 40'h00_1000_0000);
        op(DACS_OP_ADD, 1'b0, 40'h00_0000_0003);
        chk(acc_a, 40'h00_1000_0003);
        op(DACS_OP_SUB, 1'b0, 40'h00_0000_0005);
        chk(acc_a, 40'h00_0FFF_FFFE);
        op(DACS_OP_LOAD, 1'b1, 40'hFF_FFFF_FFF0);
        chk(acc_a, 40'h00_0FFF_FFFE);
        req.shift_en = 1'b1;
        op(DACS_OP_ADD, 1'b1, 40'h00_0000_0008);
        chk(acc_b, 40'h00_0000_0000);
    endtask

    task automatic t_guard();
        cfg.first_guard_trap_en = 1'b1;
        op(DACS_OP_LOAD, 1'b0, 40'h00_FFFF_FFFF);
        op(DACS_OP_ADD, 1'b0, 40'h00_0000_0001);
        chkf(flg.first_acc_guard_ovf, 1'b1);
        chkf(flg.any_acc_guard_ovf, 1'b1);
        chkf(trap, 1'b1);
        op(DACS_OP_SUB, 1'b0, 40'h00_0000_0001);
        chkf(flg.first_acc_guard_ovf, 1'b0);
        chkf(trap, 1'b0);
        cfg = '0;
    endtask

    task automatic t_sat();
        cfg.first_acc_clip_en = 1'b1;
        cfg.clip_width_sel = 1'b1;
        op(DACS_OP_LOAD, 1'b0, 40'h7F_FFFF_FFFF);
        op(DACS_OP_ADD, 1'b0, 40'h00_0000_0001);
        chk(acc_a, 40'h7F_FFFF_FFFF);
        chkf(flg.any_acc_clip_flag, 1'b1);
        op(DACS_OP_NONE, 1'b0, 40'h00_0000_0000);
        chkf(flg.first_acc_clip_flag, 1'b1);
        clr();
        chkf(flg.first_acc_clip_flag, 1'b0);
        op(DACS_OP_LOAD, 1'b0, 40'h80_0000_0005);
        op(DACS_OP_SUB, 1'b0, 40'h00_0000_0010);
        chk(acc_a, 40'h80_0000_0000);
        clr();
        cfg.clip_width_sel = 1'b0;
        op(DACS_OP_LOAD, 1'b0, 40'h00_7FFF_FFF0);
        op(DACS_OP_ADD, 1'b0, 40'h00_0000_0020);
        chk(acc_a, 40'h00_7FFF_FFFF);
        chkf(flg.first_acc_clip_flag, 1'b1);
        chkf(flg.first_acc_guard_ovf, 1'b0);
        op(DACS_OP_LOAD, 1'b0, 40'hFF_8000_0000);
        op(DACS_OP_SUB, 1'b0, 40'h00_0000_0001);
        chk(acc_a, 40'h00_8000_0000);
        clr();
        cfg.fatal_ovf_trap_en = 1'b1;
        op(DACS_OP_LOAD, 1'b1, 40'h7F_FFFF_FFFF);
        op(DACS_OP_ADD, 1'b1, 40'h00_0000_0001);
        chk(acc_b, 40'h80_0000_0000);
        chkf(flg.second_acc_clip_flag, 1'b1);
        chkf(flg.second_acc_guard_ovf, 1'b1);
        chkf(trap, 1'b1);
        clr();
        cfg = '0;
    endtask

    task automatic t_store();
        st(40'h00_1234_8000, DACS_OP_STORE, 1'b1, 1'b0, 16'h1234);
        chk({24'h00_0000, addr}, 40'h00_0000_0000);
        st(40'h00_1234_8000, DACS_OP_STORE_RND, 1'b1, 1'b0, 16'h1235);
        st(40'h00_1234_7FFF, DACS_OP_STORE_RND, 1'b1, 1'b0, 16'h1234);
        st(40'h00_1234_8000, DACS_OP_STORE_RND, 1'b0, 1'b0, 16'h1234);
        st(40'h00_1235_8000, DACS_OP_STORE_RND, 1'b0, 1'b0, 16'h1236);
        st(40'h00_1234_8001, DACS_OP_STORE_RND, 1'b0, 1'b0, 16'h1235);
        st(40'h01_0000_0000, DACS_OP_STORE, 1'b0, 1'b1, 16'h7FFF);
        st(40'hFE_0000_0000, DACS_OP_STORE, 1'b0, 1'b1, 16'h8000);
        st(40'h00_1234_0000, DACS_OP_STORE, 1'b0, 1'b1, 16'h1234);
        cfg = '0;
    endtask

    task automatic t_wb();
        cfg.round_style_sel = 1'b1;
        op(DACS_OP_LOAD, 1'b1, 40'h00_4321_8000);
        op(DACS_OP_LOAD, 1'b0, 40'h00_0000_0100);
        op(DACS_OP_MULT_ACCUM, 1'b0, 40'h00_0000_0010, DACS_WB_POST_INC);
        chkf(wr, 1'b1);
        chk({24'h00_0000, data}, 40'h00_0000_4322);
        chk({24'h00_0000, ptr}, 40'h00_0000_0002);
        chk(acc_a, 40'h00_0000_0110);
        op(DACS_OP_MULT_SUB, 1'b0, 40'h00_0000_0010, DACS_WB_POST_INC);
        chk({24'h00_0000, addr}, 40'h00_0000_0002);
        chk({24'h00_0000, ptr}, 40'h00_0000_0004);
        op(DACS_OP_MULT_ACCUM, 1'b0, 40'h00_0000_0000, DACS_WB_REG);
        chk({24'h00_0000, m_addr}, 40'h00_0000_0002);
        chk({24'h00_0000, ptr}, 40'h00_0000_4322);
        for (int i = 0; i < 4; i++) begin
            op(nw[i], 1'b0, 40'h00_0000_0001, DACS_WB_POST_INC);
            chkf(wr, 1'b0);
            chk({24'h00_0000, ptr}, 40'h00_0000_4322);
        end
        chk({24'h00_0000, m_data}, 40'h00_0000_4322);
    endtask

    initial begin
        err_total = 0;
        checks = 0;
        rstn_in = 1'b0;
        cfg = '0;
        req = '0;
        clr_a = 1'b0;
        clr_b = 1'b0;
        repeat (20) @(posedge clk_in);
        #1 rstn_in = 1'b1;
        chk(acc_a, 40'h00_0000_0000);
        chkf(flg.any_acc_clip_flag, 1'b0);
        t_add();
        t_guard();
        t_sat();
        t_store();
        t_wb();
        stop_test();
    end

    initial begin
        #40_000;
        err_total++;
        $display("BAD %0t watchdog expired", $time);
        stop_test();
    end
endmodule // dacs_accum_bench

bind dacs_accum dacs_accum_properties u_props (.clk_in(clk_in), .rstn_in(rstn_in), .cfg_in(cfg_in),
    .req_in(req_in), .clear_first_clip_in(clear_first_clip_in), .clear_second_clip_in(clear_second_clip_in),
    .first_acc_out(first_acc_out), .second_acc_out(second_acc_out), .flags_out(flags_out),
    .arith_trap_out(arith_trap_out), .xbus_wr_out(xbus_wr_out), .xbus_addr_out(xbus_addr_out),
    .xbus_data_out(xbus_data_out), .writeback_ptr_out(writeback_ptr_out));
